// ### logic/scu_map.vh
// constants and rule overview for the serial communication unit
//
// Overview of operation
// - 16-bit divisor 2..65535 gives a 16x or 1x bit rate
// - one frame layout in async and sync; expansion sends no start bit
// - data width of 5 to 8 bits
// - even, odd or no parity, sent and checked
// - stop of 1 to 2.5 bits in async, 2 to 5 bits in 1x modes, then line idles high
// - async start on falling edge; short false starts rejected
// - optional ninth bit follows data; one marks an address
// - address match sets pending flag, then data is accepted
// - sends a line break and reports a received one
// - local loopback and auto-echo diagnostic paths
// - separate transmit, receive, line and address requests
// - divider runs on internal or receive clock; data taken on rising edge
// - clock pin gives baud clock, or data-only clock in expansion
// - clock pin rests low when not clocking
// - holding value moves to free shifter, updating holding-empty
// - unused upper holding bits ignored
// - received word buffered at end; unused upper bits read one
// - transmit dma starts only after a program write
// - fastest rate is internal clock over two in 1x mode
// - async samples once at mid-bit out of sixteen ticks per bit, sync once per tick
// - expansion receive latches on external clock's rising edge
`ifndef SCU_MAP_VH
`define SCU_MAP_VH
`define SCU_DIV_MIN        16'h0002
`define SCU_MODE_ASYNC     2'h0
`define SCU_MODE_SYNC      2'h1
`define SCU_MODE_EXPAND    2'h2
`define SCU_PAR_NONE       2'h0
`define SCU_PAR_EVEN       2'h1
`define SCU_PAR_ODD        2'h2
`define SCU_FIFO_DEPTH     8
`define SCU_FIFO_AW        3
`define SCU_OVERSAMPLE     4'hF
`define SCU_MID_SAMPLE     4'h7
`endif

// ### logic/scu_fifo.v
// parameterised flip-flop fifo with valid and ready on both sides
module scu_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             core_clk,
    input  wire             rst_b,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            push;
    wire            pop;

    assign in_ready  = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            end
            if (push & ~pop) begin
                count <= count + 1'b1;
            end else if (pop & ~push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // scu_fifo

// ### logic/scu_serial_comm_unit.v
// serial communication unit: baud divider, transmitter, receiver, diagnostics
`include "scu_map.vh"
module scu_serial_comm_unit #(
    parameter DIV_W = 16
) (
    input  wire             core_clk,
    input  wire             rst_b,
    input  wire [1:0]       mode,
    input  wire [1:0]       data_len,
    input  wire [1:0]       parity_sel,
    input  wire [1:0]       stop_sel,
    input  wire             addr_bit_en,
    input  wire             addr_wake_mode,
    input  wire [7:0]       addr_compare,
    input  wire [DIV_W-1:0] baud_divisor,
    input  wire             baud_src_ext,
    input  wire             clk_out_sel_baud,
    input  wire             loopback_en,
    input  wire             echo_en,
    input  wire             send_break,
    input  wire             tx_dma_en,
    input  wire [7:0]       tx_data,
    input  wire             tx_addr_flag,
    input  wire             tx_valid,
    output wire             tx_ready,
    input  wire             tx_cpu_write,
    output wire [7:0]       rx_data,
    output wire             rx_addr_flag,
    output wire             rx_valid,
    input  wire             rx_ready,
    input  wire             rx_addr_pending_clr,
    output reg              rx_addr_pending,
    output reg              rx_parity_err,
    output reg              rx_frame_err,
    output reg              rx_break,
    output reg              tx_holding_empty_flag,
    output reg              tx_shift_empty,
    output wire             tx_irq,
    output wire             rx_irq,
    output wire             line_irq,
    output wire             addr_irq,
    output wire             tx_dma_req,
    input  wire             serial_line_in,
    output wire             serial_line_out,
    input  wire             ext_receive_clock_in,
    input  wire             ext_transmit_clock_in,
    output reg              shift_clock_out
);
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function [3:0] width_of;
        input [1:0] len;
        begin
            width_of = {2'b00, len} + 4'h5;
        end
    endfunction

    function [7:0] mask_data;
        input [7:0] d;
        input [1:0] len;
        begin
            mask_data = d & (8'hFF >> (2'h3 - len));
        end
    endfunction

    // ------------------------------------------------------------------
    // baud divider and bit-rate enables
    // ------------------------------------------------------------------
    reg  [DIV_W-1:0] div_cnt;
    reg              ext_rx_q;
    reg              baud_tick;
    reg              baud_clk;
    wire             ext_rx_rise = ext_receive_clock_in & ~ext_rx_q;
    wire             src_en      = baud_src_ext ? ext_rx_rise : 1'b1;
    wire [DIV_W-1:0] div_eff     = (baud_divisor < `SCU_DIV_MIN) ? `SCU_DIV_MIN : baud_divisor;
    wire             is_async    = (mode == `SCU_MODE_ASYNC);
    wire             is_expand   = (mode == `SCU_MODE_EXPAND);

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            div_cnt   <= {DIV_W{1'b0}};
            ext_rx_q  <= 1'b0;
            baud_tick <= 1'b0;
            baud_clk  <= 1'b0;
        end else begin
            ext_rx_q  <= ext_receive_clock_in;
            baud_tick <= 1'b0;
            if (src_en) begin
                if (div_cnt >= div_eff - 1'b1) begin
                    div_cnt   <= {DIV_W{1'b0}};
                    baud_tick <= 1'b1;
                    baud_clk  <= 1'b1;
                end else begin
                    if (div_cnt == (div_eff >> 1) - 1'b1) begin
                        baud_clk <= 1'b0;
                    end
                    div_cnt <= div_cnt + 1'b1;
                end
            end
        end
    end

    // 16x in async, 1x otherwise
    reg  [3:0] tx_os;
    wire       tx_bit_en   = baud_tick & (is_async ? (tx_os == `SCU_OVERSAMPLE) : 1'b1);
    wire       tx_half_en  = baud_tick & (is_async ? (tx_os[2:0] == 3'h7) : 1'b1);

    // ------------------------------------------------------------------
    // transmit path: fifo feeds holding register, holding feeds shifter
    // ------------------------------------------------------------------
    wire [8:0] fifo_out;
    wire       fifo_valid;
    reg        hold_full;
    reg  [8:0] hold_word;
    reg        dma_armed;
    reg        tx_busy;
    reg  [11:0] tx_shift;
    reg  [3:0] tx_bits_left;
    reg  [2:0] tx_stop_halves;
    reg        tx_in_stop;
    reg        tx_line;
    reg        tx_data_phase;
    reg        tx_shift_ev;
    wire       fifo_pop = fifo_valid & ~hold_full;

    scu_fifo #(
        .WIDTH (9),
        .DEPTH (`SCU_FIFO_DEPTH),
        .AW    (`SCU_FIFO_AW)
    ) u_tx_fifo (
        .core_clk  (core_clk),
        .rst_b     (rst_b),
        .in_data   ({tx_addr_flag, tx_data}),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .out_data  (fifo_out),
        .out_valid (fifo_valid),
        .out_ready (~hold_full)
    );

    // data, parity, address bit, frame built lsb first
    reg [11:0] frame;
    reg [3:0]  frame_len;
    reg        par_bit;
    always @* begin
        par_bit   = ^mask_data(hold_word[7:0], data_len) ^ (addr_bit_en & hold_word[8])
                    ^ (parity_sel == `SCU_PAR_ODD);
        frame_len = width_of(data_len);
        frame     = {4'hF, mask_data(hold_word[7:0], data_len)};
        if (parity_sel != `SCU_PAR_NONE) begin
            frame[frame_len] = par_bit;
            frame_len        = frame_len + 4'h1;
        end
        if (addr_bit_en) begin
            frame[frame_len] = hold_word[8];
            frame_len        = frame_len + 4'h1;
        end
    end

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            hold_full             <= 1'b0;
            hold_word             <= 9'h000;
            dma_armed             <= 1'b0;
            tx_busy               <= 1'b0;
            tx_shift              <= 12'hFFF;
            tx_bits_left          <= 4'h0;
            tx_stop_halves        <= 3'h0;
            tx_in_stop            <= 1'b0;
            tx_line               <= 1'b1;
            tx_data_phase         <= 1'b0;
            tx_os                 <= 4'h0;
            tx_holding_empty_flag <= 1'b1;
            tx_shift_empty        <= 1'b1;
            tx_shift_ev           <= 1'b0;
        end else begin
            tx_shift_ev <= 1'b0;
            if (baud_tick) begin
                tx_os <= tx_os + 4'h1;
            end
            if (tx_cpu_write) begin
                dma_armed <= 1'b1;
            end else if (!tx_dma_en) begin
                dma_armed <= 1'b0;
            end
            if (fifo_pop) begin
                hold_full             <= 1'b1;
                hold_word             <= fifo_out;
                tx_holding_empty_flag <= 1'b0;
            end
            if (!tx_busy && hold_full && !fifo_pop) begin
                // shifter free: take holding value now
                hold_full             <= 1'b0;
                tx_holding_empty_flag <= 1'b1;
                tx_busy               <= 1'b1;
                tx_shift_empty        <= 1'b0;
                tx_shift              <= frame;
                tx_bits_left          <= frame_len;
                tx_in_stop            <= 1'b0;
                tx_os                 <= 4'h0;
                tx_line               <= ~is_expand ? 1'b0 : tx_line;
                tx_data_phase         <= 1'b0;
            end else if (tx_busy && !tx_in_stop && tx_bit_en) begin
                if (tx_bits_left == 4'h0) begin
                    tx_in_stop     <= 1'b1;
                    tx_data_phase  <= 1'b0;
                    tx_line        <= 1'b1;
                    tx_stop_halves <= {1'b0, stop_sel} + 3'h2;
                end else begin
                    tx_line       <= tx_shift[0];
                    tx_shift      <= {1'b1, tx_shift[11:1]};
                    tx_bits_left  <= tx_bits_left - 4'h1;
                    tx_data_phase <= 1'b1;
                end
            end else if (tx_busy && tx_in_stop && tx_half_en) begin
                if (tx_stop_halves <= 3'h1) begin
                    tx_busy        <= 1'b0;
                    tx_in_stop     <= 1'b0;
                    tx_shift_empty <= 1'b1;
                    tx_shift_ev    <= 1'b1;
                end else begin
                    tx_stop_halves <= tx_stop_halves - 3'h1;
                end
            end
        end
    end

    assign tx_dma_req = tx_dma_en & dma_armed & tx_ready;
    assign tx_irq     = tx_holding_empty_flag | tx_shift_ev;

    // ------------------------------------------------------------------
    // line muxing: break, echo, loopback
    // ------------------------------------------------------------------
    wire rx_pin  = loopback_en ? (tx_line & ~send_break) : serial_line_in;
    assign serial_line_out = loopback_en ? 1'b1 :
                             send_break  ? 1'b0 :
                             echo_en     ? serial_line_in : tx_line;

    // ------------------------------------------------------------------
    // clock pin
    // ------------------------------------------------------------------
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            shift_clock_out <= 1'b0;
        end else if (is_expand && !clk_out_sel_baud) begin
            shift_clock_out <= tx_data_phase & tx_busy & baud_clk;
        end else if (clk_out_sel_baud) begin
            shift_clock_out <= baud_clk;
        end else begin
            shift_clock_out <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // receiver
    // ------------------------------------------------------------------
    reg        rx_in_q;
    reg        rx_busy;
    reg  [3:0] rx_os;
    reg  [3:0] rx_bits_left;
    reg  [3:0] rx_total;
    reg  [10:0] rx_shift;
    reg        rx_load;
    reg  [8:0] rx_word;
    reg        rx_all_zero;
    reg        rx_push;
    wire       rx_fifo_ready;
    // expansion receive runs on the partner's clock
    wire       rx_tick   = is_expand ? ext_rx_rise : baud_tick;
    wire       rx_sample = rx_tick & (is_async ? (rx_os == `SCU_MID_SAMPLE) : 1'b1);
    wire [3:0] rx_len    = width_of(data_len) + {3'h0, parity_sel != `SCU_PAR_NONE}
                           + {3'h0, addr_bit_en};
    wire [10:0] rx_aligned = rx_shift >> (4'hB - rx_total);

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_in_q         <= 1'b1;
            rx_busy         <= 1'b0;
            rx_os           <= 4'h0;
            rx_bits_left    <= 4'h0;
            rx_total        <= 4'h0;
            rx_shift        <= 11'h000;
            rx_load         <= 1'b0;
            rx_word         <= 9'h000;
            rx_all_zero     <= 1'b1;
            rx_push         <= 1'b0;
            rx_addr_pending <= 1'b0;
            rx_parity_err   <= 1'b0;
            rx_frame_err    <= 1'b0;
            rx_break        <= 1'b0;
        end else begin
            rx_in_q <= rx_pin;
            rx_load <= 1'b0;
            rx_push <= rx_load & (~addr_wake_mode | rx_addr_pending);
            if (rx_addr_pending_clr) begin
                rx_addr_pending <= 1'b0;
            end
            if (!rx_busy) begin
                if ((rx_in_q & ~rx_pin) | (!is_async & !rx_pin & rx_tick)) begin
                    rx_busy      <= 1'b1;
                    rx_os        <= 4'h0;
                    rx_bits_left <= rx_len;
                    rx_total     <= rx_len;
                    rx_all_zero  <= 1'b1;
                    rx_shift     <= 11'h000;
                end
            end else if (rx_tick) begin
                rx_os <= rx_os + 4'h1;
                if (rx_sample) begin
                    rx_os <= is_async ? 4'h8 : 4'h0;
                    if (rx_bits_left == rx_total && is_async && rx_pin) begin
                        rx_busy <= 1'b0;
                    end
                    rx_bits_left <= rx_bits_left - 4'h1;
                    if (rx_bits_left == 4'hF) begin
                        rx_busy <= 1'b0; // stop bit reached
                        rx_load <= 1'b1;
                        rx_frame_err <= rx_frame_err | ~rx_pin;
                        rx_break <= rx_break | (rx_all_zero & ~rx_pin);
                    end else if (rx_bits_left != rx_total || !is_async) begin
                        rx_shift    <= {rx_pin, rx_shift[10:1]};
                        rx_all_zero <= rx_all_zero & ~rx_pin;
                    end
                end
            end
            if (rx_load) begin
                rx_word <= {addr_bit_en & rx_aligned[rx_total - 4'h1],
                            rx_aligned[7:0] | ~(8'hFF >> (2'h3 - data_len))};
                rx_parity_err <= rx_parity_err | ((parity_sel != `SCU_PAR_NONE)
                    && ((^(rx_aligned & ~(11'h7FF << rx_total)))
                    ^ (parity_sel == `SCU_PAR_ODD)));
                if (addr_wake_mode && addr_bit_en && rx_aligned[rx_total - 4'h1]
                    && mask_data(rx_aligned[7:0], data_len) == addr_compare) begin
                    rx_addr_pending <= 1'b1;
                end
            end
        end
    end

    scu_fifo #(
        .WIDTH (9),
        .DEPTH (`SCU_FIFO_DEPTH),
        .AW    (`SCU_FIFO_AW)
    ) u_rx_fifo (
        .core_clk  (core_clk),
        .rst_b     (rst_b),
        .in_data   (rx_word),
        .in_valid  (rx_push),
        .in_ready  (rx_fifo_ready),
        .out_data  ({rx_addr_flag, rx_data}),
        .out_valid (rx_valid),
        .out_ready (rx_ready)
    );

    assign rx_irq   = rx_valid;
    assign line_irq = rx_parity_err | rx_frame_err | rx_break | ~rx_fifo_ready;
    assign addr_irq = rx_addr_pending;
endmodule // scu_serial_comm_unit

// ### tb/scu_remote_node.sv
// remote serial node model driving the unit's receive line
module scu_remote_node #(
    parameter int BIT = 32
) (
    input  wire logic core_clk,
    output logic      line
);
    timeunit 1ns;
    timeprecision 1ns;
    initial line = 1'b1;
    task automatic send(input logic [15:0] bits, input int n);
        int i;
        for (i = 0; i < n; i++) begin
            @(negedge core_clk);
            line = bits[i];
            repeat (BIT - 1) @(negedge core_clk);
        end
        line = 1'b1;
    endtask
    task automatic glitch(input int len);
        @(negedge core_clk);
        line = 1'b0;
        repeat (len) @(negedge core_clk);
        line = 1'b1;
    endtask
endmodule // scu_remote_node

// ### tb/scu_checker_assertions.sv
// concurrent checks on the ports of the serial communication unit
module scu_checker #(
    parameter int DIV_W = 16
) (
    input wire logic             core_clk,
    input wire logic             rst_b,
    input wire logic [1:0]       mode,
    input wire logic [DIV_W-1:0] baud_divisor,
    input wire logic             send_break,
    input wire logic             echo_en,
    input wire logic             loopback_en,
    input wire logic             clk_out_sel_baud,
    input wire logic             tx_valid,
    input wire logic             tx_ready,
    input wire logic             tx_shift_empty,
    input wire logic             tx_holding_empty_flag,
    input wire logic             tx_dma_en,
    input wire logic             tx_cpu_write,
    input wire logic             tx_dma_req,
    input wire logic             rx_valid,
    input wire logic             rx_ready,
    input wire logic [7:0]       rx_data,
    input wire logic             rx_addr_pending_clr,
    input wire logic             rx_addr_pending,
    input wire logic             rx_break,
    input wire logic             serial_line_out,
    input wire logic             shift_clock_out
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    logic armed;
    logic quiet;
    // set by the first program write
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) armed <= 1'b0;
        else if (tx_cpu_write) armed <= 1'b1;
    end
    assign quiet = mode == 2'h0 && !send_break && !echo_en && !loopback_en;
    a_reset_idle: assert property (
        $rose(rst_b) |-> serial_line_out && !shift_clock_out && tx_holding_empty_flag)
        else $error("line not idle after reset");
    a_idle_high: assert property (
        quiet && tx_shift_empty && tx_holding_empty_flag |-> serial_line_out)
        else $error("line low while idle");
    a_push_start: assert property (
        quiet && tx_valid && tx_ready && tx_shift_empty && tx_holding_empty_flag
        |-> ##[1:4] !serial_line_out)
        else $error("no start bit after push");
    a_start_len: assert property (
        quiet && baud_divisor == 16'h0002 && $fell(serial_line_out)
        |-> !serial_line_out [*8] ##24 !serial_line_out)
        else $error("start bit too short");
    a_clk_rest: assert property (
        mode == 2'h2 && !clk_out_sel_baud && tx_shift_empty |-> !shift_clock_out)
        else $error("clock pin not resting low");
    a_break_hold: assert property (
        rx_break |=> rx_break)
        else $error("break flag lost");
    a_pend_clear: assert property (
        rx_addr_pending_clr |=> !rx_addr_pending)
        else $error("pending flag not cleared");
    a_dma_gate: assert property (
        tx_dma_req |-> tx_dma_en && (armed || tx_cpu_write))
        else $error("dma request before program write");
    a_rx_hold: assert property (
        rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
        else $error("receive word changed before pop");
endmodule // scu_checker

// ### tb/tb_top.sv
// self-checking testbench for the serial communication unit
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk = 0, rst_b = 0, addr_bit_en = 0, addr_wake_mode = 0;
    logic        loopback_en = 0, send_break = 0, tx_dma_en = 0, tx_addr_flag = 0;
    logic        tx_valid = 0, tx_cpu_write = 0, rx_ready = 0, rx_addr_pending_clr = 0;
    logic        echo_en = 0, clk_out_sel_baud = 0;
    logic [1:0]  mode = 2'h0, data_len = 2'h3, parity_sel = 2'h0, stop_sel = 2'h2;
    logic [7:0]  addr_compare = 8'h3C, tx_data = 8'h00;
    logic [15:0] baud_divisor = 16'h0002;
    wire  [7:0]  rx_data;
    wire         tx_ready, rx_addr_flag, rx_valid, rx_addr_pending, rx_break, tx_dma_req;
    wire         tx_holding_empty_flag, tx_shift_empty, serial_line_out, shift_clock_out;
    wire         node_line;
    int          err_count = 0, compares = 0, fl, i, k, c;
    logic [8:0]  last;
    logic [15:0] f;
    logic        prev;
    logic [11:0] cases [3] = '{12'hCA5, 12'h1F3, 12'hA5A};
    logic [8:0]  awords [3] = '{9'h055, 9'h13C, 9'h011};
    always #25 core_clk = ~core_clk;
    scu_serial_comm_unit #(.DIV_W(16)) i_scu_serial_comm_unit (
        .core_clk, .rst_b, .mode, .data_len, .parity_sel, .stop_sel, .addr_bit_en,
        .addr_wake_mode, .addr_compare, .baud_divisor, .baud_src_ext(1'b0),
        .clk_out_sel_baud, .loopback_en, .echo_en, .send_break, .tx_dma_en,
        .tx_data, .tx_addr_flag, .tx_valid, .tx_ready, .tx_cpu_write, .rx_data,
        .rx_addr_flag, .rx_valid, .rx_ready, .rx_addr_pending_clr, .rx_addr_pending,
        .rx_parity_err(), .rx_frame_err(), .rx_break, .tx_holding_empty_flag,
        .tx_shift_empty, .tx_irq(), .rx_irq(), .line_irq(), .addr_irq(), .tx_dma_req,
        .serial_line_in(node_line), .serial_line_out, .ext_receive_clock_in(1'b0),
        .ext_transmit_clock_in(1'b0), .shift_clock_out);
    scu_remote_node #(.BIT(32)) i_node (.core_clk, .line(node_line));
    task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // one frame, start first, two stop bits
    function automatic logic [15:0] frame(input logic [7:0] d, input int len, par,
                                          input logic ab);
        logic [15:0] r;
        int n;
        r = 16'hFFFE;
        for (n = 0; n < len; n++) r[n + 1] = d[n];
        n = len + 1;
        if (par != 0) begin
            r[n] = ^(d & ~(8'hFF << len)) ^ (addr_bit_en & ab) ^ (par == 2);
            n++;
        end
        if (addr_bit_en) begin
            r[n] = ab;
            n++;
        end
        fl = n + 2;
        return r;
    endfunction
    task automatic push(input logic [8:0] w);
        @(negedge core_clk);
        {tx_addr_flag, tx_data} = w;
        tx_valid = 1;
        while (tx_ready !== 1) @(negedge core_clk);
        @(negedge core_clk);
        tx_valid = 0;
    endtask
    task automatic tx_check(input logic [15:0] e);
        int j;
        for (j = 0; j < 2000 && serial_line_out !== 0; j++) @(negedge core_clk);
        repeat (16) @(negedge core_clk);
        for (j = 0; j < fl; j++) begin
            cmp(serial_line_out, e[j]);
            repeat (32) @(negedge core_clk);
        end
    endtask
    task automatic drain(output int n, output logic [8:0] w);
        n = 0;
        w = 9'h1FF;
        while (rx_valid === 1) begin
            w = {rx_addr_flag, rx_data};
            rx_ready = 1;
            @(negedge core_clk);
            rx_ready = 0;
            n++;
            @(negedge core_clk);
        end
    endtask
    initial begin
        repeat (2) @(negedge core_clk);
        cmp({serial_line_out, shift_clock_out, tx_ready, rx_valid, tx_holding_empty_flag},
            9'h015);
        rst_b = 1;
        tx_dma_en = 1;
        repeat (4) @(negedge core_clk);
        cmp(tx_dma_req, 9'h000);
        tx_cpu_write = 1;
        @(negedge core_clk);
        tx_cpu_write = 0;
        tx_dma_en = 0;
        $display("test reset and dma done");
        for (k = 0; k < 3; k++) begin
            {data_len, parity_sel, tx_data} = cases[k];
            f = frame(tx_data, data_len + 5, parity_sel, 1'b0);
            push({1'b0, tx_data});
            tx_check(f);
        end
        $display("test transmit formats done");
        data_len = 2'h0;
        parity_sel = 2'h1;
        echo_en = 1;
        fork
            i_node.glitch(4);
            begin
                repeat (2) @(negedge core_clk);
                cmp(serial_line_out, 9'h000);
            end
        join
        echo_en = 0;
        repeat (400) @(negedge core_clk);
        cmp(rx_valid, 9'h000);
        f = frame(8'h13, 5, 1, 1'b0);
        i_node.send(f, fl);
        for (i = 0; i < 200 && rx_valid !== 1; i++) @(negedge core_clk);
        drain(c, last);
        cmp(last, 9'h0F3);
        $display("test receive done");
        data_len = 2'h3;
        parity_sel = 2'h0;
        addr_bit_en = 1;
        addr_wake_mode = 1;
        for (k = 0; k < 3; k++) begin
            f = frame(awords[k][7:0], 8, 0, awords[k][8]);
            i_node.send(f, fl);
            repeat (100) @(negedge core_clk);
            if (k == 0) cmp(rx_valid, 9'h000);
            if (k == 1) cmp(rx_addr_pending, 9'h001);
        end
        drain(c, last);
        cmp(last, 9'h011);
        rx_addr_pending_clr = 1;
        @(negedge core_clk);
        rx_addr_pending_clr = 0;
        addr_bit_en = 0;
        addr_wake_mode = 0;
        $display("test address wake done");
        loopback_en = 1;
        c = 0;
        tx_valid = 1;
        while (tx_ready === 1 && c < 20) begin
            tx_data = c[7:0];
            @(negedge core_clk);
            c++;
        end
        tx_valid = 0;
        cmp(9'(c >= 8 && c <= 10), 9'h001);
        repeat ((c + 1) * 11 * 32) @(negedge core_clk);
        drain(k, last);
        cmp(9'(k), 9'h008);
        cmp(last, 9'h007);
        send_break = 1;
        repeat (500) @(negedge core_clk);
        send_break = 0;
        repeat (200) @(negedge core_clk);
        cmp(rx_break, 9'h001);
        loopback_en = 0;
        $display("test loopback buffer and break done");
        mode = 2'h2;
        push(9'h0A5);
        prev = 0;
        for (k = 0; k < 2; k++) begin
            c = 0;
            for (i = 0; i < (k ? 20 : 800); i++) begin
                @(negedge core_clk);
                if (shift_clock_out === 1 && !prev) c++;
                prev = shift_clock_out;
            end
            cmp(9'(c), k ? 9'h00A : 9'h008);
            clk_out_sel_baud = 1;
        end
        $display("test expansion clock done");
        conclude();
    end
    initial begin
        #(40000 * 50);
        err_count++;
        conclude();
    end
endmodule // tb_top
bind scu_serial_comm_unit scu_checker #(.DIV_W(DIV_W)) i_scu_checker (
    .core_clk, .rst_b, .mode, .baud_divisor, .send_break, .echo_en, .loopback_en,
    .clk_out_sel_baud, .tx_valid, .tx_ready, .tx_shift_empty, .tx_holding_empty_flag,
    .tx_dma_en, .tx_cpu_write, .tx_dma_req, .rx_valid, .rx_ready, .rx_data,
    .rx_addr_pending_clr, .rx_addr_pending, .rx_break, .serial_line_out, .shift_clock_out);
